/* hw/amd_decode.sv */
// opcode fetch, operand gathering and effective-address generation
// assumes req/ack memories: data is valid in the cycle ack is high
`timescale 1ns/1ps
`default_nettype none
// How it works
// - seventeen operand modes in nine families are decoded from the opcode
// - long modes build full sixteen-bit operand addresses
// - long modes fetch more bytes or pointer bytes than short ones
// - short direct and indirect modes address page zero only; short indexed sums can carry past it
// - read-modify-write classes with long modes are refused as illegal
// - inherent opcodes take no operand bytes
// - immediate opcodes take one literal byte
// - short direct takes one address byte as the operand address
// - set-mask opcode raises the interrupt mask to level three
// - clear-mask opcode lowers the interrupt mask to level zero
// - wait opcode enters low power until an interrupt arrives
// - halt opcode stops the oscillator until an interrupt arrives
// - long direct fetches a sixteen-bit address in two bytes
// - indexed address is index plus offset, unsigned
// - relative modes add a signed byte offset to the counter
module amd_decode
  import amd_pkg::*;
(
  input  wire logic        clk,
  input  wire logic        rst,
  output logic      [15:0] pm_addr,
  output logic             pm_req,
  input  wire logic        pm_ack,
  input  wire logic [7:0]  pm_rdata,
  output logic      [15:0] dm_addr,
  output logic             dm_req,
  input  wire logic        dm_ack,
  input  wire logic [7:0]  dm_rdata,
  input  wire logic [7:0]  idx_x,
  input  wire logic [7:0]  idx_y,
  input  wire logic        irq_pending,
  input  wire logic        rel_take,
  output logic      [15:0] pc,
  output logic             op_valid,
  output logic      [7:0]  op_code,
  output logic      [4:0]  op_mode,
  output logic      [15:0] eff_addr,
  output logic      [7:0]  imm_data,
  output logic      [15:0] rel_target,
  output logic             op_illegal,
  output logic      [1:0]  irq_mask,
  output logic             wait_lp,
  output logic             osc_stop
);

  amd_state_t  state_reg;
  amd_state_t  state_next;
  logic [15:0] pc_reg;
  logic [15:0] pc_next;
  logic [7:0]  op_reg;
  logic [7:0]  b1_reg;
  logic [7:0]  b2_reg;
  logic [15:0] ptr_reg;
  logic [1:0]  left_reg;
  logic [1:0]  pleft_reg;
  logic [1:0]  nb_reg;
  logic [1:0]  np_reg;
  logic [15:0] op_pc_reg;
  logic [4:0]  mode_w;
  logic [2:0]  cls_w;
  logic [1:0]  opnd_w;
  logic [1:0]  ptrn_w;
  logic        long_w;
  logic        ok_w;
  logic        bad_w;
  logic        rel_w;
  logic [7:0]  idx_w;
  logic [15:0] ea_w;
  logic [15:0] tgt_w;
  logic [7:0]  pbase_w;

  // opcode fields
  assign mode_w  = op_reg[OP_MODE_MSB:OP_MODE_LSB];
  assign cls_w   = op_reg[OP_CLS_MSB:OP_CLS_LSB];
  assign idx_w   = cls_w[CLS_Y_BIT-OP_CLS_LSB] ? idx_y : idx_x;
  assign bad_w   = !ok_w || ((mode_w != M_INH) && cls_w[CLS_RMW_BIT-OP_CLS_LSB]
                   && long_w);
  assign rel_w   = (mode_w == M_REL_D) || (mode_w == M_REL_I) ||
                   (mode_w == M_BTJ_D) || (mode_w == M_BTJ_I);
  assign pbase_w = (nb_reg == LEN_NONE) ? pm_rdata : b1_reg;

  amd_mode_tab u_tab (
    .mode     (mode_w),
    .opnd_cnt (opnd_w),
    .ptr_cnt  (ptrn_w),
    .is_long  (long_w),
    .mode_ok  (ok_w)
  );

  amd_ea_gen u_ea (
    .mode       (mode_w),
    .b1         (b1_reg),
    .b2         (b2_reg),
    .ptr        (ptr_reg),
    .idx        (idx_w),
    .pc         (pc_reg),
    .ea         (ea_w),
    .rel_target (tgt_w)
  );

  // sequencer next state and program counter
  always_comb begin
    state_next = state_reg;
    pc_next    = pc_reg;
    case (state_reg)
      S_OPF: begin
        if (pm_ack) begin
          state_next = S_DEC;
          pc_next    = pc_reg + ADDR_INC;
        end
      end
      S_DEC: begin
        if (bad_w) begin
          state_next = S_OPF;
          pc_next    = pc_reg + {14'h0000, opnd_w}; // skip refused operands
        end else if (opnd_w != LEN_NONE) begin
          state_next = S_OPN;
        end else begin
          state_next = S_EMIT;
        end
      end
      S_OPN: begin
        if (pm_ack) begin
          pc_next = pc_reg + ADDR_INC;
          if (left_reg == LEN_BYTE) begin
            state_next = (ptrn_w != LEN_NONE) ? S_PTR : S_EMIT;
          end
        end
      end
      S_PTR: begin
        if (dm_ack && (pleft_reg == LEN_BYTE)) begin
          state_next = S_EMIT;
        end
      end
      S_EMIT: begin
        state_next = S_OPF;
        if (mode_w == M_INH && cls_w == wait_for_irq_op) begin
          state_next = S_WFI;
        end else if (mode_w == M_INH && cls_w == halt_osc_op) begin
          state_next = S_HALT;
        end
        if (rel_w && rel_take) begin
          pc_next = tgt_w;
        end
      end
      S_WFI, S_HALT: begin
        if (irq_pending) begin
          state_next = S_OPF;
        end
      end
      default: state_next = S_OPF;
    endcase
  end

  // state and counter
  always_ff @(posedge clk) begin
    if (rst) begin
      state_reg <= S_OPF;
      pc_reg    <= PC_RESET;
    end else begin
      state_reg <= state_next;
      pc_reg    <= pc_next;
    end
  end

  // opcode capture
  always_ff @(posedge clk) begin
    if (rst) begin
      op_reg    <= 8'h00;
      op_pc_reg <= PC_RESET;
    end else if (state_reg == S_OPF && pm_ack) begin
      op_reg    <= pm_rdata;
      op_pc_reg <= pc_reg;
    end
  end

  // operand bytes, first then second
  always_ff @(posedge clk) begin
    if (rst) begin
      b1_reg   <= 8'h00;
      b2_reg   <= 8'h00;
      left_reg <= LEN_NONE;
      nb_reg   <= LEN_NONE;
    end else if (state_reg == S_DEC) begin
      b1_reg   <= 8'h00;
      b2_reg   <= 8'h00;
      left_reg <= opnd_w;
      nb_reg   <= LEN_NONE;
    end else if (state_reg == S_OPN && pm_ack) begin
      if (nb_reg == LEN_NONE) begin
        b1_reg <= pm_rdata;
      end else begin
        b2_reg <= pm_rdata;
      end
      left_reg <= left_reg - LEN_BYTE;
      nb_reg   <= nb_reg + LEN_BYTE;
    end
  end

  // pointer read, high byte first for a word
  always_ff @(posedge clk) begin
    if (rst) begin
      ptr_reg   <= 16'h0000;
      pleft_reg <= LEN_NONE;
      np_reg    <= LEN_NONE;
    end else if (state_reg == S_DEC) begin
      ptr_reg   <= 16'h0000;
      pleft_reg <= ptrn_w;
      np_reg    <= LEN_NONE;
    end else if (state_reg == S_PTR && dm_ack) begin
      ptr_reg   <= {ptr_reg[7:0], dm_rdata};
      pleft_reg <= pleft_reg - LEN_BYTE;
      np_reg    <= np_reg + LEN_BYTE;
    end
  end

  // memory requests, registered ahead of the state they serve
  always_ff @(posedge clk) begin
    if (rst) begin
      pm_req  <= 1'b0;
      pm_addr <= PC_RESET;
      dm_req  <= 1'b0;
      dm_addr <= 16'h0000;
    end else begin
      pm_req  <= (state_next == S_OPF) || (state_next == S_OPN);
      pm_addr <= pc_next;
      dm_req  <= (state_next == S_PTR);
      if (state_reg == S_OPN && state_next == S_PTR) begin
        dm_addr <= {PAGE_ZERO, pbase_w}; // pointer sits in page zero
      end else if (state_reg == S_PTR && dm_ack) begin
        dm_addr <= dm_addr + ADDR_INC;
      end
    end
  end

  // decoded operation handed on
  always_ff @(posedge clk) begin
    if (rst) begin
      op_valid   <= 1'b0;
      op_code    <= 8'h00;
      op_mode    <= M_INH;
      eff_addr   <= 16'h0000;
      imm_data   <= 8'h00;
      rel_target <= PC_RESET;
      op_illegal <= 1'b0;
    end else begin
      op_valid   <= (state_reg == S_EMIT);
      op_illegal <= (state_reg == S_DEC) && bad_w;
      if (state_reg == S_EMIT) begin
        op_code    <= op_reg;
        op_mode    <= mode_w;
        eff_addr   <= ea_w;
        imm_data   <= b1_reg;
        rel_target <= tgt_w;
      end
    end
  end

  // interrupt mask level
  always_ff @(posedge clk) begin
    if (rst) begin
      irq_mask <= IMASK_RESET;
    end else if (state_reg == S_EMIT && mode_w == M_INH) begin
      if (cls_w == set_irq_mask_op) begin
        irq_mask <= IMASK_LEVEL3;
      end else if (cls_w == clear_irq_mask_op) begin
        irq_mask <= IMASK_LEVEL0;
      end
    end
  end

  // low power flags
  always_ff @(posedge clk) begin
    if (rst) begin
      wait_lp  <= 1'b0;
      osc_stop <= 1'b0;
    end else begin
      wait_lp  <= (state_next == S_WFI);
      osc_stop <= (state_next == S_HALT);
    end
  end

  assign pc = pc_reg;

  // checks
  chk_mode_range: assert property (@(posedge clk) disable iff (rst)
    op_valid |-> op_mode <= M_BTJ_I) else $error("mode out of range");
  chk_long_reach: assert property (@(posedge clk) disable iff (rst)
    op_valid && op_mode == M_DIR_L |-> eff_addr == {b1_reg, b2_reg})
    else $error("long direct address wrong");
  chk_long_ptr: assert property (@(posedge clk) disable iff (rst)
    op_valid && (op_mode == M_IND_L || op_mode == M_IIX_L) |-> np_reg == LEN_WORD)
    else $error("long pointer not two bytes");
  chk_page_zero: assert property (@(posedge clk) disable iff (rst)
    op_valid && (op_mode == M_DIR_S || op_mode == M_IND_S || op_mode == M_BIT_D)
    |-> eff_addr[15:8] == PAGE_ZERO) else $error("short mode left page zero");
  chk_rmw_short: assert property (@(posedge clk) disable iff (rst)
    op_valid && op_mode != M_INH && op_code[CLS_RMW_BIT] |->
    !(op_mode inside {M_DIR_L, M_IDX_L, M_IND_L, M_IIX_L}))
    else $error("long mode passed on rmw class");
  chk_inh_len: assert property (@(posedge clk) disable iff (rst)
    op_valid && op_mode == M_INH |-> nb_reg == LEN_NONE && pc_reg == op_pc_reg + ADDR_INC)
    else $error("inherent took operand bytes");
  chk_imm_len: assert property (@(posedge clk) disable iff (rst)
    op_valid && op_mode == M_IMM |-> nb_reg == LEN_BYTE && imm_data == b1_reg)
    else $error("immediate length wrong");
  chk_dir_short: assert property (@(posedge clk) disable iff (rst)
    op_valid && op_mode == M_DIR_S |-> eff_addr == {PAGE_ZERO, b1_reg})
    else $error("short direct address wrong");
  chk_mask_set: assert property (@(posedge clk) disable iff (rst)
    op_valid && op_mode == M_INH && op_code[7:5] == set_irq_mask_op |->
    irq_mask == IMASK_LEVEL3) else $error("mask not raised");
  chk_mask_clr: assert property (@(posedge clk) disable iff (rst)
    op_valid && op_mode == M_INH && op_code[7:5] == clear_irq_mask_op |->
    irq_mask == IMASK_LEVEL0) else $error("mask not lowered");
  chk_wait_hold: assert property (@(posedge clk) disable iff (rst)
    wait_lp && !irq_pending |=> wait_lp && !pm_req) else $error("left wait early");
  chk_halt_hold: assert property (@(posedge clk) disable iff (rst)
    osc_stop && !irq_pending |=> osc_stop) else $error("left halt early");
  chk_dir_two: assert property (@(posedge clk) disable iff (rst)
    op_valid && op_mode == M_DIR_L |-> nb_reg == LEN_WORD) else $error("long direct bytes");
  chk_idx_sum: assert property (@(posedge clk) disable iff (rst)
    op_valid && op_mode == M_IDX_S |->
    eff_addr == {PAGE_ZERO, b1_reg} + {PAGE_ZERO, $past(idx_w)})
    else $error("indexed sum wrong");
  chk_rel_add: assert property (@(posedge clk) disable iff (rst)
    op_valid && op_mode == M_REL_D |->
    rel_target == $past(pc_reg) + {{8{b1_reg[7]}}, b1_reg}) else $error("relative wrong");
  chk_pc_step: assert property (@(posedge clk) disable iff (rst)
    state_reg == S_OPN && pm_ack |=> pc_reg == $past(pc_reg) + ADDR_INC)
    else $error("pc not stepped");

  cov_btj_ind: cover property (@(posedge clk) op_valid && op_mode == M_BTJ_I);
  cov_iix_long: cover property (@(posedge clk) op_valid && op_mode == M_IIX_L);
  cov_refused: cover property (@(posedge clk) op_illegal);
  cov_wake: cover property (@(posedge clk) wait_lp ##1 !wait_lp);

endmodule // amd_decode
`default_nettype wire

/* hw/amd_ea_gen.sv */
// effective address and relative target from the gathered bytes
// assumes operand and pointer bytes already fetched and stable
`timescale 1ns/1ps
`default_nettype none
module amd_ea_gen
  import amd_pkg::*;
(
  input  wire logic [4:0]  mode,
  input  wire logic [7:0]  b1,
  input  wire logic [7:0]  b2,
  input  wire logic [15:0] ptr,
  input  wire logic [7:0]  idx,
  input  wire logic [15:0] pc,
  output logic      [15:0] ea,
  output logic      [15:0] rel_target
);

  logic [15:0] idx16;
  logic [7:0]  off;

  assign idx16 = {PAGE_ZERO, idx};

  // address per mode; indexed sums are unsigned
  always_comb begin
    ea = {PAGE_ZERO, b1};
    case (mode)
      M_DIR_L:          ea = {b1, b2};
      M_IDX_0:          ea = idx16;
      M_IDX_S:          ea = {PAGE_ZERO, b1} + idx16;
      M_IDX_L:          ea = {b1, b2} + idx16;
      M_IND_S, M_BIT_I,
      M_BTJ_I:          ea = {PAGE_ZERO, ptr[7:0]};
      M_IND_L:          ea = ptr;
      M_IIX_S:          ea = {PAGE_ZERO, ptr[7:0]} + idx16;
      M_IIX_L:          ea = ptr + idx16;
      default:          ea = {PAGE_ZERO, b1};
    endcase
  end

  // signed 8-bit offset added to the next-instruction address
  always_comb begin
    case (mode)
      M_REL_I:          off = ptr[7:0];
      M_BTJ_D, M_BTJ_I: off = b2;
      default:          off = b1;
    endcase
    rel_target = pc + {{8{off[7]}}, off};
  end

endmodule // amd_ea_gen
`default_nettype wire

/* hw/amd_mode_tab.sv */
// mode table: operand bytes, pointer bytes and reach for each mode
// assumes a mode code from the opcode's low field
`timescale 1ns/1ps
`default_nettype none
module amd_mode_tab
  import amd_pkg::*;
(
  input  wire logic [4:0] mode,
  output logic      [1:0] opnd_cnt,
  output logic      [1:0] ptr_cnt,
  output logic            is_long,
  output logic            mode_ok
);

  // byte counts per mode, undefined codes flagged
  always_comb begin
    opnd_cnt = LEN_NONE;
    ptr_cnt  = LEN_NONE;
    is_long  = 1'b0;
    mode_ok  = 1'b1;
    case (mode)
      M_INH, M_IDX_0:                    opnd_cnt = LEN_NONE;
      M_IMM, M_DIR_S, M_IDX_S, M_REL_D,
      M_BIT_D:                           opnd_cnt = LEN_BYTE;
      M_DIR_L, M_IDX_L: begin
        opnd_cnt = LEN_WORD;
        is_long  = 1'b1;
      end
      M_IND_S, M_IIX_S, M_REL_I, M_BIT_I: begin
        opnd_cnt = LEN_BYTE;
        ptr_cnt  = LEN_BYTE;
      end
      M_IND_L, M_IIX_L: begin
        opnd_cnt = LEN_BYTE;
        ptr_cnt  = LEN_WORD;
        is_long  = 1'b1;
      end
      M_BTJ_D:                           opnd_cnt = LEN_WORD;
      M_BTJ_I: begin
        opnd_cnt = LEN_WORD;
        ptr_cnt  = LEN_BYTE;
      end
      default:                           mode_ok  = 1'b0;
    endcase
  end

endmodule // amd_mode_tab
`default_nettype wire

/* include/amd_pkg.sv */
// constants and types for the addressing-mode decoder
// assumes one 100 MHz clock domain and byte-wide program and data memory
package amd_pkg;

  // bus widths
  localparam int ADDR_W = 16;
  localparam int DATA_W = 8;

  // seventeen operand addressing modes in nine families
  typedef enum logic [4:0] {
    M_INH   = 5'h00,  // inherent
    M_IMM   = 5'h01,  // immediate
    M_DIR_S = 5'h02,  // direct short
    M_DIR_L = 5'h03,  // direct long
    M_IDX_0 = 5'h04,  // indexed, no offset
    M_IDX_S = 5'h05,  // indexed, byte offset
    M_IDX_L = 5'h06,  // indexed, word offset
    M_IND_S = 5'h07,  // indirect, byte pointer
    M_IND_L = 5'h08,  // indirect, word pointer
    M_IIX_S = 5'h09,  // indirect indexed, byte pointer
    M_IIX_L = 5'h0A,  // indirect indexed, word pointer
    M_REL_D = 5'h0B,  // relative, offset follows opcode
    M_REL_I = 5'h0C,  // relative, offset in memory
    M_BIT_D = 5'h0D,  // bit, direct
    M_BIT_I = 5'h0E,  // bit, indirect
    M_BTJ_D = 5'h0F,  // bit test and jump, direct
    M_BTJ_I = 5'h10   // bit test and jump, indirect
  } amd_mode_t;

  // sequencer states
  typedef enum logic [2:0] {
    S_OPF  = 3'h0,  // opcode fetch
    S_DEC  = 3'h1,  // decode
    S_OPN  = 3'h2,  // operand byte fetch
    S_PTR  = 3'h3,  // pointer read from data memory
    S_EMIT = 3'h4,  // hand decoded operation on
    S_WFI  = 3'h5,  // low power, clock running
    S_HALT = 3'h6   // oscillator stopped
  } amd_state_t;

  // inherent operations, held in the class field
  typedef enum logic [2:0] {
    no_op             = 3'h0,
    set_irq_mask_op   = 3'h1,
    clear_irq_mask_op = 3'h2,
    wait_for_irq_op   = 3'h3,
    halt_osc_op       = 3'h4
  } amd_inh_t;

  // opcode field layout
  localparam int OP_MODE_LSB = 0;
  localparam int OP_MODE_MSB = 4;
  localparam int OP_CLS_LSB  = 5;
  localparam int OP_CLS_MSB  = 7;
  localparam int CLS_Y_BIT   = 5;
  localparam int CLS_RMW_BIT = 6;

  // byte counts
  localparam logic [1:0] LEN_NONE = 2'h0;
  localparam logic [1:0] LEN_BYTE = 2'h1;
  localparam logic [1:0] LEN_WORD = 2'h2;

  // interrupt mask levels
  localparam logic [1:0] IMASK_LEVEL3 = 2'h3;
  localparam logic [1:0] IMASK_LEVEL0 = 2'h0;
  localparam logic [1:0] IMASK_RESET  = 2'h3;

  // address constants
  localparam logic [7:0]  PAGE_ZERO = 8'h00;
  localparam logic [15:0] PC_RESET  = 16'h0000;
  localparam logic [15:0] ADDR_INC  = 16'h0001;

endpackage

/* sim/amd_mem_model.sv */
// byte-wide memory that answers the decoder's req/ack reads
// assumes one clock; the bench fills mem by hierarchy, program memory while go is low
`timescale 1ns/1ps
`default_nettype none
module amd_mem_model
  import amd_pkg::*;
(
  input  wire logic        clk,
  input  wire logic        rst,
  input  wire logic        req,
  input  wire logic [15:0] addr,
  input  wire logic        go,
  input  wire logic [3:0]  lat,
  output logic             ack,
  output logic      [7:0]  rdata
);
  logic [7:0] mem [0:65535];
  logic [3:0] wait_reg;
  logic [7:0] last_reg;

  // cycles the present request has waited, cleared on each answer
  always_ff @(posedge clk) begin
    if (rst || !req || ack) begin
      wait_reg <= 4'h0;
    end else if (wait_reg != 4'hF) begin
      wait_reg <= wait_reg + 4'h1;
    end
  end

  // answer once the chosen latency has passed and the bench allows it
  assign ack = req && go && (wait_reg >= lat);

  // last byte handed out; between answers the bus shows its inverse
  always_ff @(posedge clk) begin
    if (rst) begin
      last_reg <= 8'h5A;
    end else if (ack) begin
      last_reg <= mem[addr];
    end
  end

  assign rdata = ack ? mem[addr] : ~last_reg;  // never a stale valid byte
endmodule // amd_mem_model
`default_nettype wire

/* sim/cpu_addressing_mode_decode_bench.sv */
// self-checking bench for the addressing-mode decoder
// assumes amd_decode with two amd_mem_model memories on its buses
`timescale 1ns/1ps
`default_nettype none
module cpu_addressing_mode_decode_bench
  import amd_pkg::*;
;
  logic        clk, rst, pm_req, pm_ack, dm_req, dm_ack, pm_go;
  logic        irq_pending, rel_take, op_valid, op_illegal, wait_lp, osc_stop;
  logic [15:0] pm_addr, dm_addr, pc, eff_addr, rel_target, ploc;
  logic [7:0]  pm_rdata, dm_rdata, idx_x, idx_y, op_code, imm_data;
  logic [4:0]  op_mode;
  logic [1:0]  irq_mask;
  logic [3:0]  pm_lat, dm_lat;
  int          err_total, check_count;

  // free-running 100 MHz clock
  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end

  amd_decode DUT (.clk(clk), .rst(rst), .pm_addr(pm_addr), .pm_req(pm_req),
    .pm_ack(pm_ack), .pm_rdata(pm_rdata), .dm_addr(dm_addr), .dm_req(dm_req),
    .dm_ack(dm_ack), .dm_rdata(dm_rdata), .idx_x(idx_x), .idx_y(idx_y),
    .irq_pending(irq_pending), .rel_take(rel_take), .pc(pc), .op_valid(op_valid),
    .op_code(op_code), .op_mode(op_mode), .eff_addr(eff_addr), .imm_data(imm_data),
    .rel_target(rel_target), .op_illegal(op_illegal), .irq_mask(irq_mask),
    .wait_lp(wait_lp), .osc_stop(osc_stop));

  amd_mem_model pmem_m (.clk(clk), .rst(rst), .req(pm_req), .addr(pm_addr),
    .go(pm_go), .lat(pm_lat), .ack(pm_ack), .rdata(pm_rdata));

  amd_mem_model dmem_m (.clk(clk), .rst(rst), .req(dm_req), .addr(dm_addr),
    .go(1'b1), .lat(dm_lat), .ack(dm_ack), .rdata(dm_rdata));

  // verdict and end of run
  task automatic end_sim;
    $display("checks=%0d errors=%0d", check_count, err_total);
    if (err_total == 0 && check_count > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask

  // one comparison, counted
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    check_count++;
    if (got !== exp) begin
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
      err_total++;
    end
  endtask

  task automatic tick;
    @(posedge clk);
    #1;
  endtask

  // place one program byte at the next free address
  task automatic put(input logic [7:0] b);
    pmem_m.mem[ploc] = b;
    ploc = ploc + 16'h0001;
  endtask

  // let the program bus run until one op is decoded or refused
  task automatic step;
    int n;
    n = 0;
    pm_go = 1'b1;
    do begin
      tick;
      n++;
    end while (op_valid !== 1'b1 && op_illegal !== 1'b1 && n < 300);
    pm_go = 1'b0;
    if (n >= 300) begin
      $display("BAD t=%0t got=%h exp=%h", $time, 1'b0, 1'b1);
      err_total++;
      end_sim;
    end
  endtask

  // load an instruction, decode it, check mode, address and counter
  task automatic run(input logic [7:0] op, input logic [7:0] b1, input logic [7:0] b2,
                     input int n, input logic [4:0] m, input logic [15:0] ea,
                     input bit ck_ea);
    put(op);
    if (n > 0) put(b1);
    if (n > 1) put(b2);
    step;
    chk({15'h0, op_valid}, 16'h0001);
    chk({11'h0, op_mode}, {11'h0, m});
    chk({8'h00, op_code}, {8'h00, op});
    if (ck_ea) chk(eff_addr, ea);
    chk(pc, ploc);
  endtask

  // low-power op: no fetch while asleep, wake on a pending interrupt
  task automatic sleep_wake(input logic [7:0] op, input logic [1:0] flags);
    int busy;
    int n;
    busy = 0;
    run(op, 8'h00, 8'h00, 0, M_INH, 16'h0000, 1'b0);
    chk({14'h0, wait_lp, osc_stop}, {14'h0, flags});
    pm_go = 1'b1;
    repeat (20) begin
      tick;
      if (pm_req !== 1'b0) busy++;
    end
    pm_go = 1'b0;
    chk(16'(busy), 16'h0000);
    irq_pending = 1'b1;
    n = 0;
    while (pm_req !== 1'b1 && n < 20) begin
      tick;
      n++;
    end
    irq_pending = 1'b0;
    chk({15'h0, n < 20}, 16'h0001);
    chk({14'h0, wait_lp, osc_stop}, 16'h0000);
  endtask

  task automatic t_inherent;
    run(8'h40, 8'h00, 8'h00, 0, M_INH, 16'h0000, 1'b0);
    chk({14'h0, irq_mask}, {14'h0, IMASK_LEVEL0});
    run(8'h20, 8'h00, 8'h00, 0, M_INH, 16'h0000, 1'b0);
    chk({14'h0, irq_mask}, {14'h0, IMASK_LEVEL3});
  endtask

  task automatic t_immediate;
    run(8'h01, 8'h55, 8'h00, 1, M_IMM, 16'h0000, 1'b0);
    chk({8'h00, imm_data}, 16'h0055);
  endtask

  // short direct, then long direct behind a slow program memory
  task automatic t_direct;
    run(8'h02, 8'h80, 8'h00, 1, M_DIR_S, 16'h0080, 1'b1);
    pm_lat = 4'h3;
    run(8'h03, 8'h12, 8'h34, 2, M_DIR_L, 16'h1234, 1'b1);
    pm_lat = 4'h0;
  endtask

  // sums with X and Y, carrying past one page
  task automatic t_indexed;
    idx_x = 8'hC7;
    run(8'h04, 8'h00, 8'h00, 0, M_IDX_0, 16'h00C7, 1'b1);
    idx_x = 8'h20;
    run(8'h05, 8'hF0, 8'h00, 1, M_IDX_S, 16'h0110, 1'b1);
    idx_y = 8'h30;
    run(8'h26, 8'hFF, 8'h00, 2, M_IDX_L, 16'hFF30, 1'b1);
  endtask

  // pointers in data memory, word pointer straddling a page
  task automatic t_indirect;
    dmem_m.mem[16'h0040] = 8'h9A;
    run(8'h07, 8'h40, 8'h00, 1, M_IND_S, 16'h009A, 1'b1);
    dm_lat = 4'h2;
    dmem_m.mem[16'h00FF] = 8'hAB;
    dmem_m.mem[16'h0100] = 8'hCD;
    run(8'h08, 8'hFF, 8'h00, 1, M_IND_L, 16'hABCD, 1'b1);
    dmem_m.mem[16'h0050] = 8'h10;
    dmem_m.mem[16'h0051] = 8'hF0;
    run(8'h0A, 8'h50, 8'h00, 1, M_IIX_L, 16'h1110, 1'b1);
    dm_lat = 4'h0;
  endtask

  // backward offset not taken, forward jump taken, bit test and jump
  task automatic t_relative;
    rel_take = 1'b0;
    run(8'h0B, 8'h80, 8'h00, 1, M_REL_D, 16'h0000, 1'b0);
    chk(rel_target, ploc - 16'h0080);
    rel_take = 1'b1;
    put(8'h0B);
    put(8'h03);
    step;
    rel_take = 1'b0;
    chk(rel_target, ploc + 16'h0003);
    ploc = ploc + 16'h0003;
    run(8'h0F, 8'h22, 8'hFE, 2, M_BTJ_D, 16'h0022, 1'b1);
    chk(rel_target, ploc - 16'h0002);
  endtask

  // read-modify-write: short accepted, long refused and skipped
  task automatic t_rmw;
    run(8'h42, 8'h80, 8'h00, 1, M_DIR_S, 16'h0080, 1'b1);
    put(8'h43);
    put(8'h12);
    put(8'h34);
    step;
    chk({15'h0, op_illegal}, 16'h0001);
    chk({15'h0, op_valid}, 16'h0000);
    run(8'h01, 8'h77, 8'h00, 1, M_IMM, 16'h0000, 1'b0);
  endtask

  // pointer-indexed, pointer offset, bit modes, then an undefined mode code
  task automatic t_ptr_bit;
    idx_x = 8'h10;
    dmem_m.mem[16'h0060] = 8'hF8;
    run(8'h09, 8'h60, 8'h00, 1, M_IIX_S, 16'h0108, 1'b1);
    chk({15'h0, dm_req}, 16'h0000);
    dmem_m.mem[16'h0061] = 8'hFB;
    run(8'h0C, 8'h61, 8'h00, 1, M_REL_I, 16'h0000, 1'b0);
    chk(rel_target, ploc - 16'h0005);
    run(8'h0D, 8'h33, 8'h00, 1, M_BIT_D, 16'h0033, 1'b1);
    dmem_m.mem[16'h0062] = 8'h44;
    run(8'h0E, 8'h62, 8'h00, 1, M_BIT_I, 16'h0044, 1'b1);
    dmem_m.mem[16'h0063] = 8'h55;
    run(8'h10, 8'h63, 8'h10, 2, M_BTJ_I, 16'h0055, 1'b1);
    chk(rel_target, ploc + 16'h0010);
    put(8'h11);
    step;
    chk({15'h0, op_illegal}, 16'h0001);
    chk(pc, ploc);
  endtask

  task automatic t_wait;
    sleep_wake(8'h60, 2'b10);
  endtask

  task automatic t_halt;
    sleep_wake(8'h80, 2'b01);
  endtask

  // reset, first fetch, then every scenario in turn
  initial begin
    rst = 1'b1;
    irq_pending = 1'b0;
    rel_take = 1'b0;
    idx_x = 8'h00;
    idx_y = 8'h00;
    pm_go = 1'b0;
    pm_lat = 4'h0;
    dm_lat = 4'h0;
    ploc = 16'h0000;
    err_total = 0;
    check_count = 0;
    repeat (12) tick;
    chk({14'h0, irq_mask}, {14'h0, IMASK_RESET});
    chk({15'h0, op_valid}, 16'h0000);
    rst = 1'b0;
    tick;
    chk({15'h0, pm_req}, 16'h0001);
    chk(pm_addr, PC_RESET);
    t_inherent;
    t_immediate;
    t_direct;
    t_indexed;
    t_indirect;
    t_relative;
    t_rmw;
    t_ptr_bit;
    t_wait;
    t_halt;
    end_sim;
  end
endmodule // cpu_addressing_mode_decode_bench
`default_nettype wire
